// ==== pcqd_pkg.sv ====
// Purpose: Shared constants and types of the pulse counter and quadrature decoder
// Assumes: core_clk at 100 MHz
// Notes:   Offsets are byte addresses on the plain register port
package pcqd_pkg;
   // ==========================================
   // Timing
   localparam int         CLK_PERIOD_NS = 10;
   localparam int         FILT_STEP_NS  = 1000;
   localparam int         US_CYC        = (FILT_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [6:0] US_LAST       = 7'(US_CYC - 1);
   localparam logic [3:0] HS_PULSES     = 4'hb;
   localparam logic [3:0] HS_LAST       = 4'ha;
   // ==========================================
   // Register offsets
   localparam logic [7:0] ADDR_MODE     = 8'h00;
   localparam logic [7:0] ADDR_INV      = 8'h04;
   localparam logic [7:0] ADDR_FILT     = 8'h08;
   localparam logic [7:0] ADDR_LEVEL    = 8'h14;
   localparam logic [2:0] PAGE_CTRL     = 3'h0;
   localparam logic [2:0] PAGE_CNT      = 3'h1;
   localparam logic [2:0] PAGE_FREQ     = 3'h2;
   // ==========================================
   // Fields and reset values
   localparam int         MODE_HS_BIT   = 3;
   localparam int         FILT_EN_BIT   = 15;
   localparam logic [15:0] MODE_RST     = 16'h0000;
   localparam logic [7:0] INV_RST       = 8'h00;
   localparam logic [15:0] FILT_RST     = 16'h0001;
   localparam logic [7:0] SYNC_RST      = 8'hff;
   localparam logic       LINE_IDLE     = 1'b1;
   // ==========================================
   // Modes and states
   typedef enum logic [2:0] {
      PCQD_M_DIR  = 3'h0,
      PCQD_M_UPDN = 3'h1,
      PCQD_M_FREQ = 3'h2,
      PCQD_M_UP   = 3'h3,
      PCQD_M_QUAD = 3'h4
   } pcqd_mode_t;
   typedef enum logic [1:0] {
      PCQD_FQ_IDLE = 2'b01,
      PCQD_FQ_RUN  = 2'b10
   } pcqd_fq_state_t;
endpackage

// ==== pcqd_filt.sv ====
// Purpose: Second-order noise filter for one conditioned input
// Assumes: tick is a one-cycle pulse once per filter clock period
// Notes:   Disabled filter passes the input one cycle late
`timescale 1ns/1ns
module pcqd_filt (
   input  wire logic core_clk,
   input  wire logic rst,
   input  wire logic en,
   input  wire logic tick,
   input  wire logic din,
   output logic      dout
);
   typedef struct packed {
      logic smp;
      logic out;
   } pcqd_flt_t;
   pcqd_flt_t r;
   pcqd_flt_t n;
   assign dout = r.out;
   // ==========================================
   // Two agreeing samples one period apart move the output
   always_comb begin
      n = r;
      if (!en) begin
         n.smp = din;
         n.out = din;
      end else if (tick) begin
         n.smp = din;
         if (din == r.smp) begin
            n.out = din;
         end
      end
   end
   always_ff @(posedge core_clk) begin
      if (rst) begin
         r.smp <= pcqd_pkg::LINE_IDLE;
         r.out <= pcqd_pkg::LINE_IDLE;
      end else begin
         r <= n;
      end
   end
   // ==========================================
   // Checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   property p_hold;
      en && !tick |=> $stable(r.out);
   endproperty
   a_hold: assert property (p_hold) else $error("filter output moved between ticks");
   property p_single;
      en && tick && (din != r.smp) |=> $stable(r.out);
   endproperty
   a_single: assert property (p_single) else $error("single sample passed filter");
   property p_bypass;
      !en |=> r.out == $past(din);
   endproperty
   a_bypass: assert property (p_bypass) else $error("disabled filter not transparent");
endmodule

// ==== pcqd_freq.sv ====
// Purpose: Period meter for one input, single or eleven-period average
// Assumes: fall is a one-cycle falling edge pulse
// Notes:   Result is in core_clk cycles; zero while disabled
`timescale 1ns/1ns
module pcqd_freq (
   input  wire logic        core_clk,
   input  wire logic        rst,
   input  wire logic        en,
   input  wire logic        hs,
   input  wire logic        fall,
   output logic      [31:0] period
);
   typedef struct packed {
      pcqd_pkg::pcqd_fq_state_t st;
      logic [31:0]              cnt;
      logic [35:0]              sum;
      logic [3:0]               num;
      logic [31:0]              per;
   } pcqd_fq_t;
   pcqd_fq_t    r;
   pcqd_fq_t    n;
   logic [35:0] acc;
   logic [35:0] avg;
   assign acc    = r.sum + {4'h0, r.cnt};
   assign avg    = acc / {32'h0, pcqd_pkg::HS_PULSES};
   assign period = r.per;
   // ==========================================
   // Measure edge to edge
   always_comb begin
      n = r;
      if (!en) begin
         n.st  = pcqd_pkg::PCQD_FQ_IDLE;
         n.per = 32'h0;
      end else begin
         unique case (r.st)
            pcqd_pkg::PCQD_FQ_IDLE: begin
               if (fall) begin
                  n.st  = pcqd_pkg::PCQD_FQ_RUN;
                  n.cnt = 32'h1;
                  n.sum = 36'h0;
                  n.num = 4'h0;
               end
            end
            pcqd_pkg::PCQD_FQ_RUN: begin
               if (r.cnt != 32'hffffffff) begin
                  n.cnt = r.cnt + 32'h1;
               end
               if (fall) begin
                  n.cnt = 32'h1;
                  if (!hs) begin
                     n.per = r.cnt;
                  end else if (r.num == pcqd_pkg::HS_LAST) begin
                     n.per = avg[31:0];
                     n.sum = 36'h0;
                     n.num = 4'h0;
                  end else begin
                     n.sum = acc;
                     n.num = r.num + 4'h1;
                  end
               end
            end
            default: n.st = pcqd_pkg::PCQD_FQ_IDLE;
         endcase
      end
   end
   always_ff @(posedge core_clk) begin
      if (rst) begin
         r    <= '0;
         r.st <= pcqd_pkg::PCQD_FQ_IDLE;
      end else begin
         r <= n;
      end
   end
   // ==========================================
   // Checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   property p_norm;
      en && !hs && (r.st == pcqd_pkg::PCQD_FQ_RUN) && fall |=> r.per == $past(r.cnt);
   endproperty
   a_norm: assert property (p_norm) else $error("single period not reported");
   property p_hs_wait;
      en && hs && (r.st == pcqd_pkg::PCQD_FQ_RUN) && fall && (r.num != pcqd_pkg::HS_LAST)
         |=> $stable(r.per);
   endproperty
   a_hs_wait: assert property (p_hs_wait) else $error("average reported early");
endmodule

// ==== pcqd_core.sv ====
// Purpose: Four-channel pulse counter and quadrature decoder
// Assumes: Inputs synchronous to core_clk; plain register port
// Notes:   Inputs idle high; counting is on falling edges, except mode 4, which counts every edge of A and B
//
// Behaviour
// - Falling conditioned edge counts; idle high
// - Inversion select 0 passes signal unchanged
// - Inversion select 1 inverts the signal
// - Three filters: A0B0, A1B1, A2B2A3B3
// - Filter enable and width 1-32767 us
// - Filters act in every mode
// - All filters disabled after reset
// - Pass above 2T, drop below T
// - Mode 0: B low up, high down
// - Mode 1: A falls up, B falls down
// - Mode 2 normal: one period gives frequency
// - Mode 2 fast: average of eleven periods
// - Mode 3: A falling edge counts up
// - Mode 4: A leads up, lags down
// - Up and frequency modes: eight independent inputs
//
// Added by the designer: the register addresses and the address-and-strobe port.
`timescale 1ns/1ns
module pcqd_core (
   input  wire logic        core_clk,
   input  wire logic        rst,
   input  wire logic [3:0]  channel_input_a,
   input  wire logic [3:0]  channel_input_b,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [31:0] reg_rdata
);
   // ==========================================
   // State
   typedef struct packed {
      logic [7:0]        s1;
      logic [7:0]        s2;
      logic [7:0]        prev;
      logic [6:0]        us;
      logic [2:0][14:0]  wc;
      logic [3:0][3:0]   mode;
      logic [7:0]        inv;
      logic [2:0][15:0]  filt;
      logic [7:0][31:0]  cnt;
      logic [31:0]       rdata;
   } pcqd_core_t;

   pcqd_core_t       r;
   pcqd_core_t       n;
   logic [7:0]       raw;
   logic [7:0]       cond;
   logic [7:0]       flt;
   logic [7:0]       fall;
   logic             us_tick;
   logic [2:0]       tick;
   logic [2:0][14:0] wmax;
   logic [7:0][31:0] per;
   logic [31:0]      rd_val;

   // ==========================================
   // Helpers
   function automatic logic [31:0] step(
      input logic [31:0] v,
      input logic        up,
      input logic        dn
   );
      step = v + {31'h0, up} - {31'h0, dn};
   endfunction

   function automatic logic [31:0] field16(input logic [15:0] v);
      field16 = {16'h0, v};
   endfunction

   // ==========================================
   // Input conditioning
   // Even index is input A, odd index is input B of a channel
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         raw[2*i]   = channel_input_a[i];
         raw[2*i+1] = channel_input_b[i];
      end
   end

   // Inversion follows the two synchroniser stages
   assign cond = r.s2 ^ r.inv;

   // ==========================================
   // Filter clocks
   assign us_tick = (r.us == pcqd_pkg::US_LAST);

   generate
      for (genvar g = 0; g < 3; g++) begin : g_fclk
         assign wmax[g] = (r.filt[g][14:0] == 15'h0000) ? 15'h0000
                                                         : r.filt[g][14:0] - 15'h0001;
         assign tick[g] = us_tick && (r.wc[g] >= wmax[g]);
      end
   endgenerate

   // ==========================================
   // Filters and frequency meters
   generate
      for (genvar i = 0; i < 8; i++) begin : g_in
         localparam int G = (i < 2) ? 0 : ((i < 4) ? 1 : 2);
         // Filter group selection, active in every mode
         pcqd_filt u_filt (
            .core_clk (core_clk),
            .rst      (rst),
            .en       (r.filt[G][pcqd_pkg::FILT_EN_BIT]),
            .tick     (tick[G]),
            .din      (cond[i]),
            .dout     (flt[i])
         );
         // Each input has its own meter
         pcqd_freq u_freq (
            .core_clk (core_clk),
            .rst      (rst),
            .en       (r.mode[i/2][2:0] == pcqd_pkg::PCQD_M_FREQ),
            .hs       (r.mode[i/2][pcqd_pkg::MODE_HS_BIT]),
            .fall     (fall[i]),
            .period   (per[i])
         );
      end
   endgenerate

   // Edge detect on registered filtered levels
   assign fall = r.prev & ~flt;

   // ==========================================
   // Next state
   always_comb begin
      logic       fa;
      logic       fb;
      logic       lb;
      logic       qv;
      logic       qu;
      logic [2:0] ia;
      logic [2:0] ib;
      fa = 1'b0;
      fb = 1'b0;
      lb = 1'b0;
      qv = 1'b0;
      qu = 1'b0;
      ia = 3'h0;
      ib = 3'h0;
      n      = r;
      n.s1   = raw;
      n.s2   = r.s1;
      n.prev = flt;
      n.us   = us_tick ? 7'h00 : r.us + 7'h01;

      for (int g = 0; g < 3; g++) begin
         if (us_tick) begin
            n.wc[g] = tick[g] ? 15'h0000 : r.wc[g] + 15'h0001;
         end
      end

      // Per-channel counting
      for (int c = 0; c < 4; c++) begin
         ia = 3'(2 * c);
         ib = 3'(2 * c + 1);
         fa = fall[ia];
         fb = fall[ib];
         lb = flt[ib];
         qv = (flt[ia] ^ r.prev[ia]) ^ (flt[ib] ^ r.prev[ib]);
         qu = flt[ia] ^ r.prev[ib];
         unique case (pcqd_pkg::pcqd_mode_t'(r.mode[c][2:0]))
            pcqd_pkg::PCQD_M_DIR: begin
               n.cnt[ia] = step(r.cnt[ia], fa & ~lb, fa & lb);
            end
            pcqd_pkg::PCQD_M_UPDN: begin
               n.cnt[ia] = step(r.cnt[ia], fa, fb);
            end
            pcqd_pkg::PCQD_M_UP: begin
               n.cnt[ia] = step(r.cnt[ia], fa, 1'b0);
               n.cnt[ib] = step(r.cnt[ib], fb, 1'b0);
            end
            pcqd_pkg::PCQD_M_QUAD: begin
               n.cnt[ia] = step(r.cnt[ia], qv & qu, qv & ~qu);
            end
            pcqd_pkg::PCQD_M_FREQ: begin
               n.cnt[ia] = r.cnt[ia];
            end
            default: begin
               n.cnt[ia] = r.cnt[ia];
            end
         endcase
      end

      // Register writes; a count write wins over a same-cycle edge
      if (reg_wr && (reg_addr[1:0] == 2'h0)) begin
         if (reg_addr == pcqd_pkg::ADDR_MODE) begin
            n.mode = reg_wdata[15:0];
         end
         if (reg_addr == pcqd_pkg::ADDR_INV) begin
            n.inv = reg_wdata[7:0];
         end
         for (int g = 0; g < 3; g++) begin
            if (reg_addr == 8'(pcqd_pkg::ADDR_FILT + 8'(4 * g))) begin
               n.filt[g] = reg_wdata[15:0];
            end
         end
         if (reg_addr[7:5] == pcqd_pkg::PAGE_CNT) begin
            n.cnt[reg_addr[4:2]] = reg_wdata;
         end
      end

      n.rdata = reg_rd ? rd_val : 32'h0;
   end

   // ==========================================
   // Read mux
   always_comb begin
      rd_val = 32'h0;
      if (reg_addr[1:0] == 2'h0) begin
         unique case (reg_addr[7:5])
            pcqd_pkg::PAGE_CTRL: begin
               if (reg_addr == pcqd_pkg::ADDR_MODE) begin
                  rd_val = field16(r.mode);
               end else if (reg_addr == pcqd_pkg::ADDR_INV) begin
                  rd_val = {24'h0, r.inv};
               end else if (reg_addr == pcqd_pkg::ADDR_LEVEL) begin
                  rd_val = {24'h0, flt};
               end else begin
                  for (int g = 0; g < 3; g++) begin
                     if (reg_addr == 8'(pcqd_pkg::ADDR_FILT + 8'(4 * g))) begin
                        rd_val = field16(r.filt[g]);
                     end
                  end
               end
            end
            pcqd_pkg::PAGE_CNT: begin
               rd_val = r.cnt[reg_addr[4:2]];
            end
            pcqd_pkg::PAGE_FREQ: begin
               rd_val = per[reg_addr[4:2]];
            end
            default: begin
               rd_val = 32'h0;
            end
         endcase
      end
   end

   assign reg_rdata = r.rdata;

   // ==========================================
   // Registers
   always_ff @(posedge core_clk) begin
      if (rst) begin
         r      <= '0;
         r.s1   <= pcqd_pkg::SYNC_RST;
         r.s2   <= pcqd_pkg::SYNC_RST;
         r.prev <= pcqd_pkg::SYNC_RST;
         r.mode <= pcqd_pkg::MODE_RST;
         r.inv  <= pcqd_pkg::INV_RST;
         r.filt <= {3{pcqd_pkg::FILT_RST}};
      end else begin
         r <= n;
      end
   end

   // ==========================================
   // Checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   logic [2:0] m0;
   assign m0 = r.mode[0][2:0];

   sequence s_a0_fall;
      fall[0] && !fall[1] && !reg_wr;
   endsequence

   sequence s_b0_fall;
      fall[1] && !fall[0] && !reg_wr;
   endsequence

   sequence s_a1_fall;
      fall[2] && !fall[3] && !reg_wr;
   endsequence

   sequence s_b2_fall;
      fall[5] && !fall[4] && !reg_wr;
   endsequence

   property p_up_a;
      s_a0_fall and (m0 == pcqd_pkg::PCQD_M_UP)
         |=> r.cnt[0] == $past(r.cnt[0]) + 32'h1;
   endproperty
   a_up_a: assert property (p_up_a) else $error("up mode did not count");

   property p_dir_up;
      s_a1_fall and (r.mode[1][2:0] == pcqd_pkg::PCQD_M_DIR) && !flt[3]
         |=> r.cnt[2] == $past(r.cnt[2]) + 32'h1;
   endproperty
   a_dir_up: assert property (p_dir_up) else $error("dir mode did not count up");

   property p_dir_dn;
      s_a1_fall and (r.mode[1][2:0] == pcqd_pkg::PCQD_M_DIR) && flt[3]
         |=> r.cnt[2] == $past(r.cnt[2]) - 32'h1;
   endproperty
   a_dir_dn: assert property (p_dir_dn) else $error("dir mode did not count down");

   property p_updn;
      s_b2_fall and (r.mode[2][2:0] == pcqd_pkg::PCQD_M_UPDN)
         |=> r.cnt[4] == $past(r.cnt[4]) - 32'h1;
   endproperty
   a_updn: assert property (p_updn) else $error("down strobe not counted");

   property p_up_b;
      s_b0_fall and (m0 == pcqd_pkg::PCQD_M_UP)
         |=> (r.cnt[1] == $past(r.cnt[1]) + 32'h1) && $stable(r.cnt[0]);
   endproperty
   a_up_b: assert property (p_up_b) else $error("input B count not independent");

   property p_quad_up;
      (r.mode[3][2:0] == pcqd_pkg::PCQD_M_QUAD) && !reg_wr && (flt[6] != r.prev[6])
         && (flt[7] == r.prev[7]) && (flt[6] != r.prev[7])
         |=> r.cnt[6] == $past(r.cnt[6]) + 32'h1;
   endproperty
   a_quad_up: assert property (p_quad_up) else $error("leading A not counted up");

   property p_quad_dn;
      (r.mode[3][2:0] == pcqd_pkg::PCQD_M_QUAD) && !reg_wr && (flt[6] != r.prev[6])
         && (flt[7] == r.prev[7]) && (flt[6] == r.prev[7])
         |=> r.cnt[6] == $past(r.cnt[6]) - 32'h1;
   endproperty
   a_quad_dn: assert property (p_quad_dn) else $error("lagging A not counted down");

   property p_idle;
      !reg_wr && (flt[1:0] == r.prev[1:0]) |=> $stable(r.cnt[0]);
   endproperty
   a_idle: assert property (p_idle) else $error("count moved without an edge");

   property p_us;
      us_tick |-> ##100 us_tick;
   endproperty
   a_us: assert property (p_us) else $error("microsecond step wrong");

   property p_filt_off;
      disable iff (1'b0)
      rst |=> (r.filt[0][15] == 1'b0) && (r.filt[1][15] == 1'b0) && (r.filt[2][15] == 1'b0);
   endproperty
   a_filt_off: assert property (p_filt_off) else $error("filter enabled after reset");

   property p_rd_level;
      reg_rd && (reg_addr == pcqd_pkg::ADDR_LEVEL) |=> reg_rdata == {24'h0, $past(flt)};
   endproperty
   a_rd_level: assert property (p_rd_level) else $error("level read mismatch");
endmodule

// ==== pcqd_src_model.sv ====
// Purpose: Model of the external pulse, direction and encoder sources
// Assumes: Sources idle high; changes land right after a rising edge
// Notes:   Driven by the testbench through its tasks
`timescale 1ns/1ns
module pcqd_src_model (
   input  wire logic       core_clk,
   output logic      [3:0] channel_input_a,
   output logic      [3:0] channel_input_b
);
   // ==========================================
   // State
   localparam logic [1:0] SEQ [4] = '{2'b11, 2'b01, 2'b00, 2'b10};
   int ph [4];
   initial begin
      channel_input_a = 4'hf;
      channel_input_b = 4'hf;
      foreach (ph[i]) ph[i] = 0;
   end
   // ==========================================
   // Tasks
   task automatic wt(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   // Active low pulse, lo cycles low then hi cycles high
   task automatic pulse(input bit on_b, input int c, input int lo, input int hi);
      if (on_b) channel_input_b[c] <= 1'b0;
      else channel_input_a[c] <= 1'b0;
      wt(lo);
      if (on_b) channel_input_b[c] <= 1'b1;
      else channel_input_a[c] <= 1'b1;
      wt(hi);
   endtask
   task automatic setb(input int c, input logic v);
      channel_input_b[c] <= v;
      wt(4);
   endtask
   // Quarter steps; forward has A leading B
   task automatic quad(input int c, input int n, input bit fwd);
      repeat (n) begin
         ph[c] = fwd ? (ph[c] + 1) % 4 : (ph[c] + 3) % 4;
         channel_input_a[c] <= SEQ[ph[c]][1];
         channel_input_b[c] <= SEQ[ph[c]][0];
         wt(4);
      end
   endtask
endmodule

// ==== pcqd_core_tb_top.sv ====
// Purpose: Self-checking testbench of the counter and decoder core
// Assumes: Counts settle within four cycles of an input edge
// Notes:   Expected values kept in integer arrays and a queue
`timescale 1ns/1ns
module pcqd_core_tb_top;
   logic        core_clk;
   logic        rst;
   logic [3:0]  channel_input_a;
   logic [3:0]  channel_input_b;
   logic [7:0]  reg_addr;
   logic [31:0] reg_wdata;
   logic        reg_wr;
   logic        reg_rd;
   logic [31:0] reg_rdata;
   int          n_fail;
   int          checks;
   int unsigned cnt [8];
   int unsigned q [$];
   int unsigned sum;
   int          n;
   int          d;
   logic [31:0] v;
   pcqd_core u_pcqd_core (
      .core_clk        (core_clk),
      .rst             (rst),
      .channel_input_a (channel_input_a),
      .channel_input_b (channel_input_b),
      .reg_addr        (reg_addr),
      .reg_wdata       (reg_wdata),
      .reg_wr          (reg_wr),
      .reg_rd          (reg_rd),
      .reg_rdata       (reg_rdata)
   );
   pcqd_src_model u_pcqd_src_model (
      .core_clk        (core_clk),
      .channel_input_a (channel_input_a),
      .channel_input_b (channel_input_b)
   );
   // ==========================================
   // Tasks
   task automatic conclude();
      $display("Checks %0d mismatches %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         n_fail++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] dt);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= dt;
      @(posedge core_clk);
      reg_wr    <= 1'b0;
      @(posedge core_clk);
   endtask
   task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] e);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd   <= 1'b0;
      @(posedge core_clk);
      chk(nm, e, reg_rdata);
   endtask
   // ==========================================
   // Clock and watchdog
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   initial begin
      repeat (100000) @(posedge core_clk);
      n_fail++;
      conclude();
   end
   // ==========================================
   // Main sequence
   initial begin
      n_fail = 0;
      checks = 0;
      rst = 1'b1;
      reg_addr = 8'h00;
      reg_wdata = 32'h0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      foreach (cnt[i]) cnt[i] = 0;
      void'($urandom(57));
      repeat (8) @(posedge core_clk);
      rst <= 1'b0;
      @(posedge core_clk);
      // Reset state and refused addresses
      for (int i = 0; i < 3; i++) rc("filt", 8'(8'h08 + 4 * i), 32'h1);
      rc("inv", pcqd_pkg::ADDR_INV, 32'h0);
      rc("level", pcqd_pkg::ADDR_LEVEL, 32'hff);
      rc("unmapped", 8'h1c, 32'h0);
      rc("unaligned", 8'h02, 32'h0);
      for (int i = 0; i < 8; i++) rc("count", 8'(8'h20 + 4 * i), 32'h0);
      // Modes: ch0 up, ch1 dir, ch2 up/down, ch3 quadrature
      wr(pcqd_pkg::ADDR_MODE, 32'h4103);
      for (int i = 0; i < 8; i += 2) begin
         cnt[i] = $urandom_range(1000, 100000);
         wr(8'(8'h20 + 4 * i), cnt[i]);
      end
      n = $urandom_range(2, 6);
      repeat (n) begin
         u_pcqd_src_model.pulse(0, 0, 3, 5);
         cnt[0]++;
         u_pcqd_src_model.pulse(1, 0, 3, 5);
         cnt[1]++;
      end
      rc("count0", 8'h20, cnt[0]);
      rc("count1", 8'h24, cnt[1]);
      for (int dir = 0; dir < 2; dir++) begin
         u_pcqd_src_model.setb(1, dir[0]);
         n = $urandom_range(1, 5);
         repeat (n) begin
            u_pcqd_src_model.pulse(0, 1, 3, 5);
            cnt[2] = dir ? cnt[2] - 1 : cnt[2] + 1;
         end
         rc("count2", 8'h28, cnt[2]);
      end
      u_pcqd_src_model.setb(1, 1'b1);
      n = $urandom_range(1, 5);
      repeat (n) begin
         u_pcqd_src_model.pulse(0, 2, 3, 5);
         cnt[4]++;
         u_pcqd_src_model.pulse(1, 2, 3, 5);
         u_pcqd_src_model.pulse(1, 2, 3, 5);
         cnt[4] -= 2;
      end
      rc("count4", 8'h30, cnt[4]);
      for (int dir = 1; dir >= 0; dir--) begin
         n = 4 * $urandom_range(1, 4);
         u_pcqd_src_model.quad(3, n, dir[0]);
         cnt[6] = dir ? cnt[6] + n : cnt[6] - n;
         rc("count6", 8'h38, cnt[6]);
      end
      // Inversion: setting it makes an internal falling edge
      wr(pcqd_pkg::ADDR_INV, 32'h1);
      cnt[0]++;
      u_pcqd_src_model.pulse(0, 0, 6, 6);
      cnt[0]++;
      rc("level", pcqd_pkg::ADDR_LEVEL, 32'hfe);
      wr(pcqd_pkg::ADDR_INV, 32'h0);
      u_pcqd_src_model.wt(6);
      rc("count0", 8'h20, cnt[0]);
      rc("level", pcqd_pkg::ADDR_LEVEL, 32'hff);
      // Filters
      wr(pcqd_pkg::ADDR_FILT, 32'hffff);
      rc("filt0", pcqd_pkg::ADDR_FILT, 32'hffff);
      wr(pcqd_pkg::ADDR_FILT, 32'h8001);
      u_pcqd_src_model.pulse(0, 0, 60, 320);
      u_pcqd_src_model.pulse(0, 0, 320, 60);
      u_pcqd_src_model.pulse(0, 0, 320, 320);
      cnt[0]++;
      rc("count0", 8'h20, cnt[0]);
      wr(pcqd_pkg::ADDR_FILT, 32'h1);
      wr(8'h0c, 32'h8001);
      u_pcqd_src_model.pulse(0, 0, 10, 10);
      cnt[0]++;
      rc("count0", 8'h20, cnt[0]);
      wr(8'h0c, 32'h1);
      // Frequency on A1 and B1
      wr(pcqd_pkg::ADDR_MODE, 32'h4123);
      d = $urandom_range(20, 80);
      v = $urandom_range(20, 80);
      fork
         repeat (3) u_pcqd_src_model.pulse(0, 1, 4, d - 4);
         repeat (3) u_pcqd_src_model.pulse(1, 1, 4, v - 4);
      join
      rc("freq2", 8'h48, d);
      rc("freq3", 8'h4c, v);
      wr(pcqd_pkg::ADDR_MODE, 32'h4153);
      rc("freq2", 8'h48, 32'h0);
      rc("freq3", 8'h4c, 32'h0);
      wr(pcqd_pkg::ADDR_MODE, 32'h41a3);
      for (int k = 0; k < 12; k++) begin
         d = $urandom_range(20, 80);
         if (k < 11) q.push_back(d);
         u_pcqd_src_model.pulse(0, 1, 4, d - 4);
      end
      sum = 0;
      foreach (q[i]) sum += q[i];
      rc("freq2", 8'h48, sum / 11);
      conclude();
   end
endmodule
